// ### blit_fifo.sv
// Source-data FIFO with valid/ready on both sides and a flush.
// Assumes depth is a power of two.
`timescale 1ns/1ps
module blit_fifo
#(
  parameter int WIDTH = 34,
  parameter int DEPTH = 8,
  parameter int LVL_W = $clog2(DEPTH + 1)
)(
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             flush,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready,
  output logic      [LVL_W-1:0] level
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [LVL_W-1:0] count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = count_reg != LVL_W'(DEPTH);
  assign out_valid = count_reg != '0;
  assign out_data  = store[rd_ptr_reg];
  assign level     = count_reg;
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;

  always_ff @(posedge clock)
  begin
    if (push)
      store[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else if (flush)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
      if (push && !pop)
        count_reg <= count_reg + LVL_W'(1);
      else if (pop && !push)
        count_reg <= count_reg - LVL_W'(1);
    end
  end

endmodule

// ### blit_mode_config.sv
// Mode, source-high and left-mask registers plus the source and pixel path of the blit engine.
// Assumes neighbouring logic supplies sizes, pitches, colours and start/abort pulses.
`timescale 1ns/1ps
// What this block does
// - Source start address is 21 bits, top five from the high register.
// - Nonzero left mask n skips first n pixels of each expanded line.
// - Expand bit picks expanded bitmap pixels, else raw source pixels.
// - Expansion maps bits MSB first to successive destination pixels.
// - Lines are byte padded; padding bits are dropped per programmed width.
// - Display-memory expand source is aligned and read linearly, pitch ignored.
// - Low three source bits pick the first pattern row under expansion.
// - Pattern copy tiles the pattern over the whole rectangle.
// - Pattern is 8, 64 or 128 bytes, always 64 pixels.
// - Width bit selects 16 or 8 bits per expanded pixel.
// - Width bit selects 16 or 8 bit transparency compare.
// - Compare on suppresses matching result writes; off writes all but left-masked expanded pixels.
// - In expand-transparency variant, zero bits are skipped or background.
// - Source select takes host data ignoring its address, else display.
// - Destination select is only exported on dst_to_host_reg; pixel results always leave on the pix_* outputs.
// - Direction bit decrements addresses from the top, else increments.
// - Set transparent-mask bits exclude positions from the compare.
// - Start launches the transfer; busy clears when it completes.
module blit_mode_config
  import blit_pkg::*;
#(
  parameter int FIFO_DEPTH    = FIFO_DEPTH_DEF,
  parameter bit EXPAND_TRANSP = 1'b0
)(
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic [7:0]        reg_index,
  input  wire logic              reg_wr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata_reg,
  input  wire logic [15:0]       src_start_low,
  input  wire logic [ADDR_W-1:0] dst_start,
  input  wire logic [12:0]       src_pitch,
  input  wire logic [12:0]       dst_pitch,
  input  wire logic [10:0]       blt_width,
  input  wire logic [9:0]        blt_height,
  input  wire logic [15:0]       fg_colour,
  input  wire logic [15:0]       bg_colour,
  input  wire logic [15:0]       trans_colour,
  input  wire logic [15:0]       trans_mask,
  input  wire logic              start_req,
  input  wire logic              abort_req,
  output logic                   busy_reg,
  output logic                   dst_to_host_reg,
  input  wire logic              host_wvalid,
  input  wire logic [WORD_W-1:0] host_wdata,
  output logic                   host_wready_reg,
  output logic                   mem_rd_req_reg,
  output logic      [ADDR_W-1:0] mem_rd_addr_reg,
  input  wire logic              mem_rd_ready,
  input  wire logic              mem_rd_valid,
  input  wire logic [7:0]        mem_rd_data,
  output logic                   pix_valid_reg,
  output logic      [15:0]       pix_data_reg,
  output logic                   pix_we_reg,
  output logic      [ADDR_W-1:0] pix_addr_reg,
  input  wire logic              pix_ready
);
  localparam int LVL_W = $clog2(FIFO_DEPTH + 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Register file and latched transfer settings.
  logic [SRC_HIGH_W-1:0]  src_high_reg;
  logic [LEFT_MASK_W-1:0] left_mask_reg;
  logic [7:0]             mode_reg;
  logic [7:0]             mode_q;
  logic [2:0]             lmask_q;
  logic [ADDR_W-1:0]      src_q, dst_q;
  logic [12:0]            spitch_q, dpitch_q;
  logic [10:0]            width_q;
  logic [9:0]             height_q;
  logic [15:0]            fg_q, bg_q, tcol_q, tmask_q;
  run_state_e             state_reg;
  logic [LVL_W-1:0]       inflight_reg;
  logic                   start_take;
  logic                   last_pix;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      src_high_reg  <= SRC_HIGH_RST;
      left_mask_reg <= LEFT_MASK_RST;
      mode_reg      <= MODE_RST;
    end
    else if (reg_wr)
    begin
      case (reg_index)
        IDX_SRC_HIGH:  src_high_reg  <= reg_wdata[SRC_HIGH_W-1:0];
        IDX_LEFT_MASK: left_mask_reg <= reg_wdata[LEFT_MASK_W-1:0];
        IDX_MODE:      mode_reg      <= reg_wdata & MODE_WR_MASK;
        default:       mode_reg      <= mode_reg;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      reg_rdata_reg <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_index)
        IDX_SRC_HIGH:  reg_rdata_reg <= {3'h0, src_high_reg};
        IDX_LEFT_MASK: reg_rdata_reg <= {5'h0, left_mask_reg};
        IDX_MODE:      reg_rdata_reg <= mode_reg;
        default:       reg_rdata_reg <= 8'h00;
      endcase
    end
  end

  assign start_take = start_req && state_reg == ST_IDLE && inflight_reg == '0;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_q   <= MODE_RST;
      lmask_q  <= LEFT_MASK_RST;
      src_q    <= '0;
      dst_q    <= '0;
      spitch_q <= '0;
      dpitch_q <= '0;
      width_q  <= '0;
      height_q <= '0;
      fg_q     <= '0;
      bg_q     <= '0;
      tcol_q   <= '0;
      tmask_q  <= '0;
    end
    else if (start_take)
    begin
      mode_q   <= mode_reg;
      lmask_q  <= left_mask_reg;
      src_q    <= {src_high_reg, src_start_low};
      dst_q    <= dst_start;
      spitch_q <= src_pitch;
      dpitch_q <= dst_pitch;
      width_q  <= blt_width;
      height_q <= blt_height;
      fg_q     <= fg_colour;
      bg_q     <= bg_colour;
      tcol_q   <= trans_colour;
      tmask_q  <= trans_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Run control.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= ST_IDLE;
      busy_reg  <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (start_take)
          begin
            state_reg <= ST_LOAD;
            busy_reg  <= 1'b1;
          end
        end
        ST_LOAD:
        begin
          state_reg <= abort_req ? ST_IDLE : ST_RUN;
          busy_reg  <= !abort_req;
        end
        ST_RUN:
        begin
          if (abort_req || last_pix)
          begin
            state_reg <= ST_IDLE;
            busy_reg  <= 1'b0;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
          busy_reg  <= 1'b0;
        end
      endcase
    end
  end

  assign dst_to_host_reg = mode_q[MODE_DST_SYS];

  ////////////////////////////////////////////////////////////////////////////////
  // Geometry derived from the latched settings.
  logic              expand, pattern, wide, transp, src_sys, dir_down, run;
  logic [11:0]       w_bytes, pix_line, pix_plus7, row_bytes, span_bytes, span_count;
  logic [ADDR_W-1:0] pat_base;
  logic [2:0]        row_start;

  assign expand     = mode_q[MODE_EXPAND];
  assign pattern    = mode_q[MODE_PATTERN];
  assign wide       = mode_q[MODE_WIDE];
  assign transp     = mode_q[MODE_TRANSP];
  assign src_sys    = mode_q[MODE_SRC_SYS];
  assign dir_down   = mode_q[MODE_DIR_DOWN];
  assign run        = state_reg == ST_RUN;
  assign w_bytes    = {1'b0, width_q} + 12'h001;
  assign pix_line   = wide ? {1'b0, w_bytes[11:1]} : w_bytes;
  assign pix_plus7  = pix_line + 12'h007;
  assign row_bytes  = expand ? PAT_ROW_MONO : (wide ? PAT_ROW_16BP : PAT_ROW_8BPP);
  assign span_bytes = pattern ? row_bytes : (expand ? {3'h0, pix_plus7[11:3]} : w_bytes);
  assign span_count = pattern ? {3'h0, pix_plus7[11:3]} : 12'h001;
  assign pat_base   = expand ? {src_q[20:3], 3'h0} : {src_q[20:2], 2'h0};
  assign row_start  = expand ? src_q[2:0] : 3'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Display-memory source address generator, bounded by FIFO credits.
  logic              g_active;
  logic [9:0]        g_line;
  logic [11:0]       g_span, g_byte, span_last;
  logic [ADDR_W-1:0] g_base, g_addr, g_next_line, g_row_off, g_row_off0;
  logic [2:0]        g_row;
  logic [LVL_W-1:0]  fifo_level;
  logic [LVL_W:0]    credit_used;
  logic              issue, req_accept;

  assign g_row_off   = {18'h0, g_row + 3'h1} * {9'h0, row_bytes};
  assign g_row_off0  = {18'h0, row_start} * {9'h0, row_bytes};
  assign span_last   = (pattern && !expand && g_span == span_count - 12'h001)
                       ? w_bytes - (span_count - 12'h001) * row_bytes - 12'h001
                       : span_bytes - 12'h001;
  assign credit_used = {1'b0, inflight_reg} + {1'b0, fifo_level} + {LVL_W'(0), mem_rd_req_reg};
  assign req_accept  = mem_rd_req_reg && mem_rd_ready;
  assign issue       = run && g_active && (!mem_rd_req_reg || mem_rd_ready)
                       && credit_used < (LVL_W+1)'(FIFO_DEPTH);

  always_comb
  begin
    if (pattern)
      g_next_line = pat_base + g_row_off;
    else if (expand)
      g_next_line = dir_down ? g_addr - 21'h1 : g_addr + 21'h1;
    else
      g_next_line = dir_down ? g_base - {8'h0, spitch_q} : g_base + {8'h0, spitch_q};
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      g_active        <= 1'b0;
      g_line          <= '0;
      g_span          <= '0;
      g_byte          <= '0;
      g_row           <= '0;
      g_base          <= '0;
      g_addr          <= '0;
      mem_rd_req_reg  <= 1'b0;
      mem_rd_addr_reg <= '0;
    end
    else if (state_reg == ST_LOAD)
    begin
      g_active <= !src_sys;
      g_line   <= '0;
      g_span   <= '0;
      g_byte   <= '0;
      g_row    <= row_start;
      g_base   <= pattern ? pat_base + g_row_off0 : src_q;
      g_addr   <= pattern ? pat_base + g_row_off0 : src_q;
    end
    else if (!run)
    begin
      g_active <= 1'b0;
      if (req_accept)
        mem_rd_req_reg <= 1'b0;
    end
    else if (issue)
    begin
      mem_rd_req_reg  <= 1'b1;
      mem_rd_addr_reg <= g_addr;
      if (g_byte != span_last)
      begin
        g_byte <= g_byte + 12'h001;
        g_addr <= dir_down ? g_addr - 21'h1 : g_addr + 21'h1;
      end
      else if (g_span != span_count - 12'h001)
      begin
        g_byte <= '0;
        g_span <= g_span + 12'h001;
        g_addr <= g_base;
      end
      else
      begin
        g_byte   <= '0;
        g_span   <= '0;
        g_row    <= g_row + 3'h1;
        g_base   <= g_next_line;
        g_addr   <= g_next_line;
        g_line   <= g_line + 10'h001;
        g_active <= g_line != height_q;
      end
    end
    else if (req_accept)
      mem_rd_req_reg <= 1'b0;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      inflight_reg <= '0;
    else if (req_accept && !mem_rd_valid)
      inflight_reg <= inflight_reg + LVL_W'(1);
    else if (mem_rd_valid && !req_accept && inflight_reg != '0)
      inflight_reg <= inflight_reg - LVL_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Source FIFO: host words or display-memory bytes with a byte count.
  logic              f_in_valid, f_in_ready, f_out_valid, f_pop;
  logic [FIFO_W-1:0] f_in_data, f_out_data;

  assign f_in_valid = state_reg != ST_IDLE
                      && (src_sys ? host_wvalid && host_wready_reg : mem_rd_valid);
  assign f_in_data  = src_sys ? {2'h3, host_wdata} : {2'h0, 24'h0, mem_rd_data};

  blit_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) src_fifo (
    .clock     (clock),
    .rstn      (rstn),
    .flush     (start_take || abort_req),
    .in_valid  (f_in_valid),
    .in_data   (f_in_data),
    .in_ready  (f_in_ready),
    .out_valid (f_out_valid),
    .out_data  (f_out_data),
    .out_ready (f_pop),
    .level     (fifo_level)
  );

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      host_wready_reg <= 1'b0;
    else
      host_wready_reg <= state_reg != ST_IDLE && !abort_req && !last_pix && src_sys
                         && fifo_level <= LVL_W'(FIFO_DEPTH - 2);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pixel former: unpack bytes, expand, clip, compare, address.
  logic [WORD_W-1:0] cur_word;
  logic [2:0]        cur_left, bit_idx;
  logic              lo_have, adv, emit, eol, cons, mono_bit, match, we;
  logic [7:0]        lo_byte, src_byte;
  logic [9:0]        c_line;
  logic [11:0]       c_pix, pix_col_reg;
  logic [15:0]       colour, pdata, diff;
  logic [ADDR_W-1:0] d_base, d_addr, d_step;
  logic              pix_bit_reg;

  assign f_pop    = run && cur_left == 3'h0 && f_out_valid;
  assign adv      = run && cur_left != 3'h0 && (!pix_valid_reg || pix_ready);
  assign src_byte = cur_word[7:0];
  assign mono_bit = src_byte[3'h7 - bit_idx];
  assign emit     = adv && (expand || !wide || lo_have);
  assign eol      = emit && c_pix == pix_line - 12'h001;
  assign last_pix = run && eol && c_line == height_q;
  assign cons     = adv && (!expand || bit_idx == 3'h7 || eol);
  assign colour   = mono_bit ? fg_q : bg_q;
  assign d_step   = wide ? 21'h2 : 21'h1;

  always_comb
  begin
    if (expand)
      pdata = wide ? colour : {8'h00, colour[7:0]};
    else
      pdata = wide ? {src_byte, lo_byte} : {8'h00, src_byte};
    diff  = (pdata ^ tcol_q) & ~tmask_q;
    match = wide ? diff == 16'h0000 : diff[7:0] == 8'h00;
    if (expand && c_pix < {9'h0, lmask_q})
      we = 1'b0;
    else if (expand && transp && EXPAND_TRANSP)
      we = mono_bit;
    else if (transp)
      we = !match;
    else
      we = 1'b1;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cur_word <= '0;
      cur_left <= '0;
      bit_idx  <= '0;
      lo_have  <= 1'b0;
      lo_byte  <= '0;
      c_line   <= '0;
      c_pix    <= '0;
      d_base   <= '0;
      d_addr   <= '0;
    end
    else if (state_reg == ST_LOAD || !run || last_pix)
    begin
      cur_left <= '0;
      bit_idx  <= '0;
      lo_have  <= 1'b0;
      c_line   <= '0;
      c_pix    <= '0;
      d_base   <= dst_q;
      d_addr   <= dst_q;
    end
    else
    begin
      if (f_pop)
      begin
        cur_word <= f_out_data[WORD_W-1:0];
        cur_left <= {1'b0, f_out_data[FIFO_W-1:WORD_W]} + 3'h1;
      end
      else if (cons)
      begin
        cur_word <= {8'h00, cur_word[WORD_W-1:8]};
        cur_left <= cur_left - 3'h1;
      end
      if (adv && !expand && wide && !lo_have)
      begin
        lo_byte <= src_byte;
        lo_have <= 1'b1;
      end
      else if (emit)
        lo_have <= 1'b0;
      if (emit && expand)
        bit_idx <= eol ? 3'h0 : bit_idx + 3'h1;
      if (emit)
      begin
        c_pix  <= eol ? 12'h000 : c_pix + 12'h001;
        c_line <= eol ? c_line + 10'h001 : c_line;
        if (eol)
        begin
          d_base <= dir_down ? d_base - {8'h0, dpitch_q} : d_base + {8'h0, dpitch_q};
          d_addr <= dir_down ? d_base - {8'h0, dpitch_q} : d_base + {8'h0, dpitch_q};
        end
        else
          d_addr <= dir_down ? d_addr - d_step : d_addr + d_step;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pix_valid_reg <= 1'b0;
      pix_data_reg  <= '0;
      pix_we_reg    <= 1'b0;
      pix_addr_reg  <= '0;
      pix_col_reg   <= '0;
      pix_bit_reg   <= 1'b0;
    end
    else if (abort_req)
      pix_valid_reg <= 1'b0;
    else if (emit)
    begin
      pix_valid_reg <= 1'b1;
      pix_data_reg  <= pdata;
      pix_we_reg    <= we;
      pix_addr_reg  <= d_addr;
      pix_col_reg   <= c_pix;
      pix_bit_reg   <= mono_bit;
    end
    else if (pix_ready)
      pix_valid_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence seq_start;
    start_req && state_reg == ST_IDLE && inflight_reg == '0;
  endsequence

  sequence seq_last;
    last_pix && !abort_req;
  endsequence

  chk_src_addr_form: assert property (seq_start
    |=> src_q == {$past(src_high_reg), $past(src_start_low)})
    else $error("source start not formed from high and low parts");
  chk_start_busy: assert property (seq_start |=> busy_reg ##1 (busy_reg || $past(abort_req)))
    else $error("start did not raise busy");
  chk_done_clear: assert property (seq_last |=> !busy_reg && state_reg == ST_IDLE)
    else $error("busy not cleared after last pixel");
  chk_cfg_hold: assert property (busy_reg && $past(busy_reg) |-> $stable(mode_q) && $stable(src_q))
    else $error("settings changed during a transfer");
  chk_left_clip: assert property (pix_valid_reg && expand && pix_col_reg < {9'h0, lmask_q} |-> !pix_we_reg)
    else $error("clipped pixel written");
  chk_expand_colour: assert property (emit && expand && !abort_req
    |=> pix_data_reg[7:0] == (pix_bit_reg ? fg_q[7:0] : bg_q[7:0]))
    else $error("expanded pixel colour wrong");
  chk_narrow_expand: assert property (emit && expand && !wide && !abort_req
    |=> pix_data_reg[15:8] == 8'h00)
    else $error("narrow expansion produced high byte");
  chk_no_compare: assert property (emit && !transp && !abort_req
    && !(expand && c_pix < {9'h0, lmask_q}) |=> pix_we_reg)
    else $error("write suppressed with compare off");
  chk_match_skip: assert property (emit && !expand && transp && match && !abort_req
    |=> !pix_we_reg)
    else $error("matching pixel written");
  chk_host_src: assert property (host_wready_reg |-> src_sys && state_reg != ST_IDLE)
    else $error("host data accepted without host source");

endmodule

// ### blit_pkg.sv
// Shared constants for the block-transfer mode and data-path control.
// Assumes an indexed register port and a single core clock.
package blit_pkg;

  localparam logic [7:0] IDX_SRC_HIGH  = 8'h2e;
  localparam logic [7:0] IDX_LEFT_MASK = 8'h2f;
  localparam logic [7:0] IDX_MODE      = 8'h30;

  localparam logic [4:0] SRC_HIGH_RST  = 5'h00;
  localparam logic [2:0] LEFT_MASK_RST = 3'h0;
  localparam logic [7:0] MODE_RST      = 8'h00;
  localparam logic [7:0] MODE_WR_MASK  = 8'hdf;

  localparam int MODE_EXPAND   = 7;
  localparam int MODE_PATTERN  = 6;
  localparam int MODE_WIDE     = 4;
  localparam int MODE_TRANSP   = 3;
  localparam int MODE_SRC_SYS  = 2;
  localparam int MODE_DST_SYS  = 1;
  localparam int MODE_DIR_DOWN = 0;

  localparam int SRC_HIGH_W  = 5;
  localparam int LEFT_MASK_W = 3;
  localparam int ADDR_W      = 21;

  localparam logic [11:0] PAT_ROW_MONO = 12'h001;
  localparam logic [11:0] PAT_ROW_8BPP = 12'h008;
  localparam logic [11:0] PAT_ROW_16BP = 12'h010;

  localparam int FIFO_DEPTH_DEF = 8;
  localparam int WORD_W         = 32;
  localparam int FIFO_W         = 34;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b10
  } run_state_e;

endpackage

// ### disp_mem_model.sv
// Display memory model for the blit source path.
// Assumes one byte per request, returned in order, with stalls.
`timescale 1ns/1ps
module disp_mem_model
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        mem_rd_req_reg,
  input  wire logic [20:0] mem_rd_addr_reg,
  output logic             mem_rd_ready,
  output logic             mem_rd_valid,
  output logic [7:0]       mem_rd_data
);
  logic [20:0] q[$];
  logic [2:0]  cnt;
  assign mem_rd_ready = (cnt != 3'h7);
  always @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      cnt <= 3'h0;
      mem_rd_valid <= 1'b0;
      mem_rd_data <= 8'h00;
      q.delete();
    end
    else
    begin
      cnt <= cnt + 3'h1;
      if (mem_rd_req_reg && mem_rd_ready)
        q.push_back(mem_rd_addr_reg);
      mem_rd_valid <= cnt[0] && q.size() != 0;
      if (cnt[0] && q.size() != 0)
        mem_rd_data <= 8'(q.pop_front()) ^ 8'h5a;
      else
        mem_rd_data <= ~mem_rd_data;
    end
endmodule

// ### tb_top.sv
// Self-checking bench for blit_mode_config.
// Assumes default FIFO depth and the compare-based transparency variant.
`timescale 1ns/1ps
module tb_top import blit_pkg::*;;
  logic clock = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, start_req = 1'b0;
  logic abort_req = 1'b0, host_wvalid = 1'b0, pix_ready = 1'b0, pix_valid_reg, pix_we_reg;
  logic busy_reg, dst_to_host_reg, host_wready_reg, mem_rd_req_reg, mem_rd_ready, mem_rd_valid;
  logic [7:0]        reg_index = 8'h00, reg_wdata = 8'h00, reg_rdata_reg, mem_rd_data;
  logic [15:0]       src_start_low = 16'h0000, fg_colour = 16'h1234, bg_colour = 16'h5678;
  logic [15:0]       trans_colour = 16'h0000, trans_mask = 16'h0000, pix_data_reg;
  logic [ADDR_W-1:0] dst_start = '0, mem_rd_addr_reg, pix_addr_reg;
  logic [12:0]       src_pitch = 13'h0000, dst_pitch = 13'h0000;
  logic [10:0]       blt_width = 11'h000;
  logic [9:0]        blt_height = 10'h000;
  logic [WORD_W-1:0] host_wdata = '0;
  logic [31:0]       rnd = 32'h0000b89a;
  logic [37:0]       expq[$];
  int                miscompares = 0, checks_done = 0;
  blit_mode_config dut (.*);
  disp_mem_model mem (.*);
  always #5 clock = ~clock;
////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic logic [37:0] px(input logic w, input logic [7:0] b, input logic [20:0] a);
    return {w, 8'h00, b, a};
  endfunction
  task automatic chk(input logic [37:0] got, input logic [37:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    @(posedge clock);
    reg_index <= idx;
    reg_wdata <= val;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    @(posedge clock);
    reg_index <= idx;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk({30'h0, reg_rdata_reg}, {30'h0, exp});
  endtask
  task automatic run(input logic [7:0] m, input logic [15:0] lo, input logic [20:0] d);
    wr(IDX_MODE, m);
    src_start_low <= lo;
    dst_start <= d;
    @(posedge clock);
    start_req <= 1'b1;
    @(posedge clock);
    start_req <= 1'b0;
  endtask
  task automatic finish_run;
    repeat (400) if (busy_reg !== 1'b0 || expq.size() != 0) @(posedge clock);
    repeat (4) @(posedge clock);
    if (expq.size() != 0 || busy_reg !== 1'b0) chk(38'h0, 38'h1);
    expq.delete();
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
////////////////////////////////////////////////////////////////////////////////
  always @(posedge clock)
  begin
    rnd <= xs(rnd);
    pix_ready <= rnd[0] | rnd[1];
    if (pix_valid_reg === 1'b1 && pix_ready === 1'b1)
      if (expq.size() == 0) chk(38'h0, 38'h1);
      else chk({pix_we_reg, pix_data_reg, pix_addr_reg}, expq.pop_front());
  end
  initial
  begin
    #200000;
    miscompares++;
    tally_and_finish;
  end
  initial
  begin
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    rd(IDX_SRC_HIGH, 8'h00);
    rd(IDX_MODE, MODE_RST);
    wr(IDX_SRC_HIGH, 8'hf3);
    wr(IDX_LEFT_MASK, 8'hff);
    wr(IDX_MODE, 8'hff);
    wr(8'h31, 8'hff);
    rd(IDX_SRC_HIGH, 8'h13);
    rd(IDX_LEFT_MASK, 8'h07);
    rd(IDX_MODE, 8'hdf);
    rd(8'h31, 8'h00);
    wr(IDX_LEFT_MASK, 8'h00);
    blt_width <= 11'h003;
    trans_colour <= 16'hff4b;
    for (int i = 0; i < 4; i++)
      expq.push_back(px(i != 1, 8'(8'h10 + i) ^ 8'h5a, 21'(21'h001000 + i)));
    run(8'h08, 16'h0010, 21'h001000);
    finish_run();
    for (int i = 0; i < 4; i++)
      expq.push_back(px(1'b1, 8'(8'h13 - i) ^ 8'h5a, 21'(21'h001003 - i)));
    run(8'h03, 16'h0013, 21'h001003);
    finish_run();
    chk({37'h0, dst_to_host_reg}, 38'h1);
    for (int i = 0; i < 2; i++)
      expq.push_back({1'b1, 8'(8'h21 + 2 * i) ^ 8'h5a, 8'(8'h20 + 2 * i) ^ 8'h5a,
                      21'(21'h003000 + 2 * i)});
    run(8'h10, 16'h0020, 21'h003000);
    finish_run();
    blt_height <= 10'h001;
    for (int i = 0; i < 8; i++)
      expq.push_back(px(1'b1, 8'(8'h40 + i + i / 4 * 4) ^ 8'h5a, 21'(21'h004000 + i % 4)));
    run(8'h40, 16'h0040, 21'h004000);
    finish_run();
    blt_height <= 10'h000;
    wr(IDX_SRC_HIGH, 8'h00);
    wr(IDX_LEFT_MASK, 8'h02);
    blt_width <= 11'h007;
    trans_colour <= bg_colour;
    for (int i = 0; i < 8; i++)
      expq.push_back(px(i >= 2 && (8'hb4 >> (7 - i)) & 8'h01,
                        (8'hb4 >> (7 - i)) & 8'h01 ? 8'h34 : 8'h78, 21'(21'h002000 + i)));
    run(8'h8c, 16'h0000, 21'h002000);
    host_wdata <= 32'h9c3e75b4;
    host_wvalid <= 1'b1;
    do @(posedge clock); while (host_wready_reg !== 1'b1);
    host_wvalid <= 1'b0;
    host_wdata <= 32'h63c18a4b;
    finish_run();
    tally_and_finish;
  end
endmodule
